// >>> design/irc_top.sv
// Initial reset controller: reset latch, key reset, CPU start state,
// stack pointer interrupt gate and shared pin defaults.
// Assumes CPU strobes are one-cycle pulses on sys_clk; pins are asynchronous.
//
// Functional notes
// - Low reset pin enters reset; CPU runs only after pin high and release.
// - Request held in a latch cleared only while the 2 Hz wave is high.
// - Build option picks key set: off, keys 0-3, keys 0-2, keys 0-1.
// - All-four option resets only when all four keys are low together.
// - Three- or two-key option resets on any pattern holding selected keys low.
// - Key reset passes a noise filter needing 1.5 msec low.
// - Noise filter idle until the oscillator starts; count from second edge.
// - Optional stage resets only after keys stay low for the authorize time.
// - Release loads program counter 0110H and clears interrupt and extension flags.
// - NMI vector at 0100H, hardware vectors at 0104H to 010EH.
// - After reset all interrupts blocked until both stack pointers are written.
// - Rewriting one pointer masks interrupts again until the other is rewritten.
// - Wide pointer wraps in 0000H-03FFH, nibble pointer in 0000H-00FFH.
// - Interrupt pushes 4 words wide and 1 nibble; call pushes 4 words wide.
// - Extension register write sets the extension flag for the next instruction.
// - At reset outputs drive high, I/O pins are inputs with optional pull-up.
// - Special pin functions are selected only by software after reset.
`timescale 1ns/100ps
module irc_top #(
    parameter int unsigned TICK_HALF = irc_pkg::TICK_HALF_OSC,
    parameter int unsigned AUTH_CNT = irc_pkg::AUTH_OSC,
    parameter irc_pkg::irc_key_opt_t KEY_OPT = irc_pkg::KEY_ALL4,
    parameter bit AUTH_EN = 1'b0,
    parameter logic [11:0] PULLUP_MASK = 12'hFFF
) (
    input wire logic sys_clk,
    input wire logic reset,
    // Board pins
    input wire logic reset_n_pin,
    input wire logic low_speed_oscillator,
    input wire logic [3:0] key_reset_inputs,
    input wire logic serial_data_pin,
    input wire logic serial_clock_pin,
    // CPU strobes
    input wire logic wsp_wr,
    input wire logic [irc_pkg::WSP_W-1:0] wsp_wdata,
    input wire logic nsp_wr,
    input wire logic [irc_pkg::NSP_W-1:0] nsp_wdata,
    input wire logic call_push,
    input wire logic call_pop,
    input wire logic int_push,
    input wire logic int_pop,
    input wire logic ext_wr,
    input wire logic [7:0] ext_wdata,
    input wire logic instr_done,
    input wire logic int_flag_wr,
    input wire logic int_flag_wdata,
    input wire logic nmi_req,
    input wire logic irq_req,
    input wire logic [2:0] irq_index,
    // Port control from software
    input wire logic [irc_pkg::PORT_W-1:0] out_data,
    input wire logic [irc_pkg::PORT_W-1:0] io_dir_out,
    input wire logic [irc_pkg::PORT_W-1:0] io_data,
    input wire logic [irc_pkg::PORT_W-1:0] io_pullup,
    input wire logic sel_timer_out,
    input wire logic sel_div_out,
    input wire logic sel_lcd,
    input wire logic sel_serial_master,
    input wire logic sel_serial_slave,
    // Special function sources
    input wire logic timer_clock_output,
    input wire logic divided_clock_output,
    input wire logic lcd_latch_output,
    input wire logic lcd_frame_output,
    input wire logic serial_data_out,
    input wire logic serial_clock_out,
    input wire logic serial_slave_ready,
    // Reset and CPU state
    output logic init_reset_q,
    output logic cpu_run_q,
    output logic pc_load_q,
    output logic [15:0] pc_value_q,
    output logic int_flag_q,
    output logic ext_flag_q,
    output logic [7:0] ext_reg_q,
    output logic [irc_pkg::WSP_W-1:0] wsp_q,
    output logic [irc_pkg::NSP_W-1:0] nsp_q,
    output logic int_unmask_q,
    output logic nmi_take_q,
    output logic irq_take_q,
    output logic [15:0] vector_q,
    // Pins
    output logic [irc_pkg::PORT_W-1:0] out_pin_q,
    output logic [irc_pkg::PORT_W-1:0] io_out_q,
    output logic [irc_pkg::PORT_W-1:0] io_oe_q,
    output logic [irc_pkg::PORT_W-1:0] io_pu_q,
    output logic serial_data_in,
    output logic serial_clock_in
);
    import irc_pkg::*;

    typedef enum logic [1:0] {
        ST_HOLD,
        ST_WAIT,
        ST_RUN
    } irc_state_t;

    localparam logic [15:0] TICK_LAST = 16'(TICK_HALF - 1);

    irc_key_if kif ();

    logic [SYNC_W-1:0] pins_s;
    logic osc_prev_q;
    logic osc_run_q;
    logic [15:0] div_q;
    logic wave_q;
    irc_state_t st_q;
    irc_state_t st_d;
    logic wsp_set_q;
    logic nsp_set_q;

    // All pins cross into sys_clk before any logic looks at them
    irc_sync #(
        .W(SYNC_W),
        .INIT(SYNC_INIT)
    ) u_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .async_in({serial_clock_pin, serial_data_pin, key_reset_inputs, low_speed_oscillator, reset_n_pin}),
        .sync_out(pins_s)
    );

    wire pin_high = pins_s[0];
    wire osc_s = pins_s[1];
    wire [3:0] keys_s = pins_s[5:2];

    // Oscillator rising edge as a one-cycle pulse
    wire osc_edge = osc_s && !osc_prev_q;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            osc_prev_q <= 1'b0;
            osc_run_q <= 1'b0;
        end else begin
            osc_prev_q <= osc_s;
            if (osc_edge) begin
                osc_run_q <= 1'b1;
            end
        end
    end

    // Key combination match; extra low keys do not block options 3 and 4
    wire [3:0] key_mask = (KEY_OPT == KEY_ALL4) ? KEY_MASK_ALL4 :
                          (KEY_OPT == KEY_K012) ? KEY_MASK_K012 :
                          (KEY_OPT == KEY_K01) ? KEY_MASK_K01 : 4'h0;
    wire key_hit = (KEY_OPT != KEY_OFF) && ((keys_s & key_mask) == 4'h0);

    assign kif.osc_edge = osc_edge;
    assign kif.osc_running = osc_run_q;
    assign kif.key_match = key_hit;

    irc_key_filter #(
        .AUTH_CNT(AUTH_CNT),
        .AUTH_EN(AUTH_EN)
    ) u_filt (
        .sys_clk(sys_clk),
        .reset(reset),
        .kif(kif)
    );

    // Release wave: high half the period, so release waits at most a quarter second
    wire div_wrap = (div_q == TICK_LAST);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            div_q <= 16'h0000;
            wave_q <= 1'b0;
        end else if (osc_edge) begin
            div_q <= div_wrap ? 16'h0000 : div_q + 16'h0001;
            if (div_wrap) begin
                wave_q <= !wave_q;
            end
        end
    end

    // Reset latch: any request sets it, only the wave on an oscillator edge clears it
    wire rst_req = !pin_high || kif.key_req;
    wire release_ok = osc_edge && wave_q;

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_HOLD: begin
                if (!rst_req) begin
                    st_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (rst_req) begin
                    st_d = ST_HOLD;
                end else if (release_ok) begin
                    st_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (rst_req) begin
                    st_d = ST_HOLD;
                end
            end
        endcase
    end

    wire releasing = (st_q == ST_WAIT) && (st_d == ST_RUN);
    wire in_reset = (st_q != ST_RUN);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_q <= ST_HOLD;
            init_reset_q <= 1'b1;
            cpu_run_q <= 1'b0;
            pc_load_q <= 1'b0;
            pc_value_q <= PC_START;
        end else begin
            st_q <= st_d;
            init_reset_q <= (st_d != ST_RUN);
            cpu_run_q <= (st_d == ST_RUN);
            pc_load_q <= releasing;
            pc_value_q <= PC_START;
        end
    end

    // Stack pointers; the natural width gives the cyclic ranges
    wire [WSP_W-1:0] wsp_push = int_push || call_push ? WSP_PUSH_PC : 10'h000;
    wire [WSP_W-1:0] wsp_pop = int_pop || call_pop ? WSP_PUSH_PC : 10'h000;
    wire [NSP_W-1:0] nsp_step_dn = int_push ? NSP_PUSH_F : 8'h00;
    wire [NSP_W-1:0] nsp_step_up = int_pop ? NSP_PUSH_F : 8'h00;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wsp_q <= WSP_RESET;
            nsp_q <= NSP_RESET;
        end else begin
            if (wsp_wr) begin
                wsp_q <= wsp_wdata;
            end else begin
                wsp_q <= wsp_q - wsp_push + wsp_pop;
            end
            if (nsp_wr) begin
                nsp_q <= nsp_wdata;
            end else begin
                nsp_q <= nsp_q - nsp_step_dn + nsp_step_up;
            end
        end
    end

    // Pair tracking: a lone rewrite after both are set re-arms the mask
    wire both_set = wsp_set_q && nsp_set_q;

    always_ff @(posedge sys_clk) begin
        if (reset || in_reset) begin
            wsp_set_q <= 1'b0;
            nsp_set_q <= 1'b0;
        end else begin
            if (wsp_wr) begin
                wsp_set_q <= 1'b1;
            end
            if (nsp_wr) begin
                nsp_set_q <= 1'b1;
            end
            if (wsp_wr && !nsp_wr && both_set) begin
                nsp_set_q <= 1'b0;
            end
            if (nsp_wr && !wsp_wr && both_set) begin
                wsp_set_q <= 1'b0;
            end
        end
    end

    // Flags: a write that lands with the clear wins, so no flag event is lost
    always_ff @(posedge sys_clk) begin
        if (reset || in_reset) begin
            int_flag_q <= 1'b0;
            ext_flag_q <= 1'b0;
            ext_reg_q <= 8'h00;
        end else begin
            if (int_flag_wr) begin
                int_flag_q <= int_flag_wdata;
            end else if (int_push) begin
                int_flag_q <= 1'b0;
            end
            if (ext_wr) begin
                ext_flag_q <= 1'b1;
                ext_reg_q <= ext_wdata;
            end else if (instr_done) begin
                ext_flag_q <= 1'b0;
            end
        end
    end

    // Interrupt acceptance; NMI outranks the maskable ones
    wire irq_idx_ok = (irq_index <= IRQ_LAST_IDX);
    wire take_nmi = cpu_run_q && both_set && nmi_req;
    wire take_irq = cpu_run_q && both_set && !nmi_req && irq_req && int_flag_q && irq_idx_ok;
    wire [15:0] irq_vec = IRQ_VEC_BASE + {12'h000, irq_index, 1'b0};

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            int_unmask_q <= 1'b0;
            nmi_take_q <= 1'b0;
            irq_take_q <= 1'b0;
            vector_q <= NMI_VEC;
        end else begin
            int_unmask_q <= both_set && !in_reset;
            nmi_take_q <= take_nmi;
            irq_take_q <= take_irq;
            if (take_nmi) begin
                vector_q <= NMI_VEC;
            end else if (take_irq) begin
                vector_q <= irq_vec;
            end
        end
    end

    // Function selects count only once the CPU runs
    wire f_timer_clock_output = sel_timer_out && !in_reset;
    wire f_divided_clock_output = sel_div_out && !in_reset;
    wire f_lcd = sel_lcd && !in_reset;
    wire f_smst = sel_serial_master && !in_reset;
    wire f_sslv = sel_serial_slave && !sel_serial_master && !in_reset;
    wire f_ser = f_smst || f_sslv;

    // Output port mux
    logic [PORT_W-1:0] out_mux;
    always_comb begin
        out_mux = out_data;
        if (f_timer_clock_output) begin
            out_mux[OUT_TIMER_CLOCK_OUTPUT_BIT] = timer_clock_output;
        end
        if (f_divided_clock_output) begin
            out_mux[OUT_DIVIDED_CLOCK_OUTPUT_BIT] = divided_clock_output;
        end
    end

    // I/O port mux: data and direction
    logic [PORT_W-1:0] io_mux;
    logic [PORT_W-1:0] oe_mux;
    always_comb begin
        io_mux = io_data;
        oe_mux = io_dir_out;
        if (f_ser) begin
            oe_mux[IO_SIN_BIT] = 1'b0;
            io_mux[IO_SERIAL_DATA_OUT_BIT] = serial_data_out;
            oe_mux[IO_SERIAL_DATA_OUT_BIT] = 1'b1;
            io_mux[IO_SCLK_BIT] = serial_clock_out;
            oe_mux[IO_SCLK_BIT] = f_smst;
        end
        if (f_sslv) begin
            io_mux[IO_SERIAL_SLAVE_READY_BIT] = serial_slave_ready;
            oe_mux[IO_SERIAL_SLAVE_READY_BIT] = 1'b1;
        end
        if (f_lcd) begin
            io_mux[IO_CL_BIT] = lcd_latch_output;
            oe_mux[IO_CL_BIT] = 1'b1;
            io_mux[IO_FR_BIT] = lcd_frame_output;
            oe_mux[IO_FR_BIT] = 1'b1;
        end
    end

    // Pull-ups only where fitted and only on pins that are inputs
    wire [PORT_W-1:0] pu_mux = io_pullup & PULLUP_MASK & ~oe_mux;

    // Pins take general-purpose defaults for as long as reset stands
    always_ff @(posedge sys_clk) begin
        if (reset || in_reset) begin
            out_pin_q <= OUT_RESET;
            io_out_q <= IO_OE_RESET;
            io_oe_q <= IO_OE_RESET;
            io_pu_q <= PULLUP_MASK;
        end else begin
            out_pin_q <= out_mux;
            io_out_q <= io_mux;
            io_oe_q <= oe_mux;
            io_pu_q <= pu_mux;
        end
    end

    // Serial inputs from the synchronised pins
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            serial_data_in <= 1'b1;
            serial_clock_in <= 1'b1;
        end else begin
            serial_data_in <= pins_s[6];
            serial_clock_in <= pins_s[7];
        end
    end
endmodule

// >>> shared/irc_pkg.sv
// Constants and types for the initial reset controller.
// Assumes a 50 MHz system clock and a 32.768 kHz low-speed oscillator pin.
package irc_pkg;
    // Clock rates
    localparam int unsigned SYS_HZ = 50000000;
    localparam int unsigned OSC_HZ = 32768;
    // Release tick: square wave of this rate, divided from the oscillator
    localparam int unsigned TICK_HZ = 2;
    localparam int unsigned TICK_HALF_OSC = OSC_HZ / (2 * TICK_HZ);
    // Key noise reject, least time, rounded up to whole oscillator cycles
    localparam int unsigned NOISE_US = 1500;
    localparam int unsigned NOISE_OSC = (NOISE_US * OSC_HZ + 999999) / 1000000;
    // Key time authorize, lower end of the window
    localparam int unsigned AUTH_MS = 1000;
    localparam int unsigned AUTH_OSC = (AUTH_MS * OSC_HZ) / 1000;
    localparam int unsigned KEY_CNT_W = 17;
    // CPU start state and vectors
    localparam logic [15:0] PC_START = 16'h0110;
    localparam logic [15:0] NMI_VEC = 16'h0100;
    localparam logic [15:0] IRQ_VEC_BASE = 16'h0104;
    localparam logic [15:0] IRQ_VEC_LAST = 16'h010E;
    localparam logic [2:0] IRQ_LAST_IDX = 3'h5;
    // Stack pointers and push depths
    localparam int unsigned WSP_W = 10;
    localparam int unsigned NSP_W = 8;
    localparam logic [9:0] WSP_PUSH_PC = 10'h004;
    localparam logic [7:0] NSP_PUSH_F = 8'h01;
    localparam logic [9:0] WSP_RESET = 10'h000;
    localparam logic [7:0] NSP_RESET = 8'h00;
    // Shared pins: port vectors hold group 0 in bits 3:0, 1 in 7:4, 2 in 11:8
    localparam int unsigned PORT_W = 12;
    localparam logic [11:0] OUT_RESET = 12'hFFF;
    localparam logic [11:0] IO_OE_RESET = 12'h000;
    localparam int unsigned OUT_TIMER_CLOCK_OUTPUT_BIT = 2;
    localparam int unsigned OUT_DIVIDED_CLOCK_OUTPUT_BIT = 3;
    localparam int unsigned IO_SIN_BIT = 4;
    localparam int unsigned IO_SERIAL_DATA_OUT_BIT = 5;
    localparam int unsigned IO_SCLK_BIT = 6;
    localparam int unsigned IO_SERIAL_SLAVE_READY_BIT = 7;
    localparam int unsigned IO_CL_BIT = 10;
    localparam int unsigned IO_FR_BIT = 11;
    // Key combination options
    typedef enum logic [1:0] {
        KEY_OFF,
        KEY_ALL4,
        KEY_K012,
        KEY_K01
    } irc_key_opt_t;
    localparam logic [3:0] KEY_MASK_ALL4 = 4'hF;
    localparam logic [3:0] KEY_MASK_K012 = 4'h7;
    localparam logic [3:0] KEY_MASK_K01 = 4'h3;
    // Synchroniser lanes
    localparam int unsigned SYNC_W = 8;
    localparam logic [7:0] SYNC_INIT = 8'hFC;
endpackage

// >>> shared/irc_key_if.sv
// Link between the reset controller top and its key filter.
// Assumes both ends run on sys_clk.
`timescale 1ns/100ps
interface irc_key_if;
    logic osc_edge;
    logic osc_running;
    logic key_match;
    logic key_req;
    modport top (output osc_edge, output osc_running, output key_match, input key_req);
    modport filt (input osc_edge, input osc_running, input key_match, output key_req);
endinterface

// >>> design/irc_sync.sv
// Two-flop synchroniser, one lane per bit.
// Assumes its inputs are asynchronous pins; reset values come from INIT.
`timescale 1ns/100ps
module irc_sync #(
    parameter int unsigned W = 8,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    // First stage feeds only the second stage
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_lane
            logic meta_q;
            always_ff @(posedge sys_clk) begin
                if (reset) begin
                    meta_q <= INIT[i];
                    sync_out[i] <= INIT[i];
                end else begin
                    meta_q <= async_in[i];
                    sync_out[i] <= meta_q;
                end
            end
        end
    endgenerate
endmodule

// >>> design/irc_key_filter.sv
// Key combination noise reject and optional time authorize.
// Assumes oscillator edges arrive as one-cycle pulses on sys_clk.
`timescale 1ns/100ps
module irc_key_filter
    import irc_pkg::*;
#(
    parameter int unsigned AUTH_CNT = irc_pkg::AUTH_OSC,
    parameter bit AUTH_EN = 1'b0
) (
    input wire logic sys_clk,
    input wire logic reset,
    irc_key_if.filt kif
);
    localparam int unsigned TARGET_I = AUTH_EN ? (NOISE_OSC + AUTH_CNT) : NOISE_OSC;
    localparam logic [KEY_CNT_W-1:0] TARGET = TARGET_I[KEY_CNT_W-1:0];

    logic [KEY_CNT_W-1:0] cnt_q;
    logic req_q;
    wire hold_ok = kif.key_match && kif.osc_running;
    wire at_target = (cnt_q == TARGET);

    // Count oscillator edges while the combination stays low; any release restarts
    always_ff @(posedge sys_clk) begin
        if (reset || !hold_ok) begin
            cnt_q <= '0;
            req_q <= 1'b0;
        end else begin
            if (kif.osc_edge && !at_target) begin
                cnt_q <= cnt_q + 1'b1;
            end
            req_q <= at_target;
        end
    end

    assign kif.key_req = req_q;
endmodule

// >>> verif/irc_properties.sv
// Concurrent checks on the reset controller top ports.
// Assumes it is bound into irc_top; one clock, synchronous reset.
`timescale 1ns/100ps
module irc_properties (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic reset_n_pin,
    input wire logic wsp_wr,
    input wire logic nsp_wr,
    input wire logic call_push,
    input wire logic int_push,
    input wire logic ext_wr,
    input wire logic [7:0] ext_wdata,
    input wire logic nmi_req,
    input wire logic [2:0] irq_index,
    input wire logic init_reset_q,
    input wire logic cpu_run_q,
    input wire logic pc_load_q,
    input wire logic [15:0] pc_value_q,
    input wire logic int_flag_q,
    input wire logic ext_flag_q,
    input wire logic [7:0] ext_reg_q,
    input wire logic [irc_pkg::WSP_W-1:0] wsp_q,
    input wire logic [irc_pkg::NSP_W-1:0] nsp_q,
    input wire logic nmi_take_q,
    input wire logic irq_take_q,
    input wire logic [15:0] vector_q,
    input wire logic [irc_pkg::PORT_W-1:0] out_pin_q,
    input wire logic [irc_pkg::PORT_W-1:0] io_oe_q
);
    import irc_pkg::*;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    // Pin low long enough to cross the synchroniser
    sequence s_pin_low;
        !reset_n_pin [*5];
    endsequence
    sequence s_release;
        $fell(init_reset_q);
    endsequence
    a_reset_entry: assert property (s_pin_low |=> init_reset_q)
        else $error("internal reset missed a held pin");
    a_run_inverse: assert property (cpu_run_q == !init_reset_q)
        else $error("cpu run disagrees with internal reset");
    a_release_start: assert property (s_release |-> pc_load_q && pc_value_q == PC_START && !int_flag_q && !ext_flag_q)
        else $error("start state wrong at release");
    a_load_pulse: assert property (pc_load_q |=> !pc_load_q && cpu_run_q)
        else $error("start load not a single pulse");
    a_pin_defaults: assert property (init_reset_q [*2] |-> out_pin_q == OUT_RESET && io_oe_q == IO_OE_RESET)
        else $error("shared pins left their defaults in reset");
    a_nmi_vector: assert property (nmi_take_q |-> vector_q == NMI_VEC && $past(nmi_req) && $past(cpu_run_q))
        else $error("nmi taken with wrong vector or cause");
    a_irq_vector: assert property (irq_take_q |-> vector_q == IRQ_VEC_BASE + {$past(irq_index), 1'b0} && !$past(nmi_req))
        else $error("irq vector does not follow its index");
    a_wide_push: assert property (call_push && cpu_run_q && !wsp_wr && !int_push && !nsp_wr
        |=> wsp_q == $past(wsp_q) - WSP_PUSH_PC && $stable(nsp_q))
        else $error("call push moved pointers wrongly");
    a_nibble_push: assert property (int_push && cpu_run_q && !nsp_wr |=> nsp_q == $past(nsp_q) - NSP_PUSH_F)
        else $error("interrupt push missed the nibble pointer");
    a_ext_flag: assert property (ext_wr && cpu_run_q |=> ext_flag_q && ext_reg_q == $past(ext_wdata))
        else $error("extension write did not set its flag");
endmodule
bind irc_top irc_properties chk_i (.*);

// >>> verif/irc_board_model.sv
// Board side: reset circuit, low-speed oscillator and key switches.
// Assumes sys_clk from the bench; oscillator is sped up for short runs.
`timescale 1ns/100ps
module irc_board_model #(
    parameter int OSC_HALF_NS = 200,
    parameter int MIN_LOW = 8
) (
    input wire logic sys_clk,
    input wire logic pin_req,
    input wire logic [3:0] keys_down,
    output logic reset_n_pin,
    output logic low_speed_oscillator,
    output logic [3:0] key_reset_inputs
);
    int low_cnt = 0;
    // Oscillator stands still until it starts, then runs free
    initial begin
        low_speed_oscillator = 1'b0;
        #1000;
        forever #(OSC_HALF_NS) low_speed_oscillator = ~low_speed_oscillator;
    end
    // Stretch every request so the pin is never low too briefly
    always @(posedge sys_clk) low_cnt <= pin_req ? MIN_LOW : (low_cnt > 0 ? low_cnt - 1 : 0);
    assign reset_n_pin = !(pin_req || low_cnt > 0);
    // Pull-ups lift released keys, pressed keys go low
    assign key_reset_inputs = ~keys_down;
endmodule

// >>> verif/test_irc_top.sv
// Self-checking bench for the initial reset controller.
// Assumes the board model drives pin, oscillator and keys.
`timescale 1ns/100ps
module test_irc_top;
    import irc_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic pin_req = 1'b1;
    logic [3:0] keys_down = 4'h0;
    logic reset_n_pin, low_speed_oscillator, serial_data_pin, serial_clock_pin;
    logic wsp_wr, nsp_wr, call_push, call_pop, int_push, int_pop, ext_wr, instr_done;
    logic int_flag_wr, int_flag_wdata, nmi_req, irq_req;
    logic [3:0] key_reset_inputs;
    logic [WSP_W-1:0] wsp_wdata, wsp_q;
    logic [NSP_W-1:0] nsp_wdata, nsp_q;
    logic [7:0] ext_wdata, ext_reg_q;
    logic [2:0] irq_index;
    logic [PORT_W-1:0] out_data, io_dir_out, io_data, io_pullup, out_pin_q, io_out_q, io_oe_q, io_pu_q;
    logic sel_timer_out, sel_div_out, sel_lcd, sel_serial_master, sel_serial_slave;
    logic timer_clock_output, divided_clock_output, lcd_latch_output, lcd_frame_output;
    logic serial_data_out, serial_clock_out, serial_slave_ready, serial_data_in, serial_clock_in;
    logic init_reset_q, cpu_run_q, pc_load_q, int_flag_q, ext_flag_q, int_unmask_q, nmi_take_q, irq_take_q;
    logic [15:0] pc_value_q, vector_q;
    int err_count = 0;
    int n_checks = 0;
    int n_nmi = 0;
    int n_mark = 0;
    // Short wave half period keeps releases near a hundred cycles
    irc_top #(.TICK_HALF(4), .AUTH_CNT(8)) uut (.*);
    irc_board_model board (.sys_clk, .pin_req, .keys_down, .reset_n_pin, .low_speed_oscillator,
        .key_reset_inputs);
    always #10 sys_clk = ~sys_clk;
    // Count taken non-maskable requests
    always @(posedge sys_clk) if (nmi_take_q === 1'b1) n_nmi <= n_nmi + 1;
    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
        cyc(2);
    endtask
    // Bounded wait: 400 cycles, five wave half periods
    task wait_run;
        for (int i = 0; i < 400 && cpu_run_q !== 1'b1; i++) cyc(1);
        chk(16'(cpu_run_q), 16'h0001);
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Watchdog: tests need about 4000 cycles, allow 20000
    initial begin
        #400000;
        err_count++;
        end_sim;
    end
    initial begin
        {wsp_wr, nsp_wr, call_push, call_pop, int_push, int_pop, ext_wr, instr_done, int_flag_wr} = '0;
        {int_flag_wdata, nmi_req, irq_req, irq_index, wsp_wdata, nsp_wdata, ext_wdata} = '0;
        {out_data, io_dir_out, io_data, io_pullup, sel_timer_out, sel_div_out, sel_lcd} = '0;
        {sel_serial_master, sel_serial_slave, timer_clock_output, divided_clock_output} = '0;
        {lcd_latch_output, lcd_frame_output, serial_data_out, serial_clock_out} = '0;
        {serial_slave_ready, serial_data_pin, serial_clock_pin} = '0;
        cyc(20);
        reset = 1'b0;
        cyc(10);
        // Power-up with the pin still low
        chk(16'({init_reset_q, cpu_run_q}), 16'h0002);
        chk(16'(out_pin_q), 16'h0FFF);
        chk(16'(io_pu_q), 16'h0FFF);
        pin_req = 1'b0;
        wait_run;
        chk(pc_value_q, 16'h0110);
        chk(16'({int_flag_q, ext_flag_q}), 16'h0000);
        // Interrupts stay masked until both pointers are written
        nmi_req = 1'b1;
        pulse(wsp_wr);
        cyc(3);
        chk(16'(n_nmi), 16'h0000);
        nsp_wdata = 8'h40;
        pulse(nsp_wr);
        cyc(3);
        chk(16'({int_unmask_q, n_nmi != 0}), 16'h0003);
        chk(vector_q, 16'h0100);
        pulse(wsp_wr);
        n_mark = n_nmi;
        cyc(3);
        chk(16'({int_unmask_q, n_nmi != n_mark}), 16'h0000);
        pulse(nsp_wr);
        cyc(3);
        chk(16'(n_nmi != n_mark), 16'h0001);
        nmi_req = 1'b0;
        // Every hardware vector in turn
        int_flag_wdata = 1'b1;
        pulse(int_flag_wr);
        irq_req = 1'b1;
        for (int i = 0; i < 6; i++) begin
            irq_index = 3'(i);
            cyc(3);
            chk(vector_q, 16'h0104 + 16'(2 * i));
        end
        irq_req = 1'b0;
        // Pushes and pops across the wrap points
        wsp_wdata = 10'h002;
        pulse(wsp_wr);
        pulse(call_push);
        chk({nsp_q, 6'h00, wsp_q}, 32'h4003FE);
        pulse(call_pop);
        chk(16'(wsp_q), 16'h0002);
        nsp_wdata = 8'h00;
        pulse(nsp_wr);
        pulse(int_push);
        chk({nsp_q, 6'h00, wsp_q}, 32'hFF03FE);
        pulse(int_pop);
        chk({nsp_q, 6'h00, wsp_q}, 32'h000002);
        ext_wdata = 8'hA5;
        pulse(ext_wr);
        chk(16'({ext_flag_q, ext_reg_q}), 16'h01A5);
        pulse(instr_done);
        chk(16'(ext_flag_q), 16'h0000);
        // Software picks special functions on the shared pins
        {out_data, io_dir_out, io_data, io_pullup} = {12'h0F3, 12'h00F, 12'h005, 12'hFFF};
        {sel_timer_out, sel_div_out, sel_lcd, sel_serial_master} = 4'hF;
        {divided_clock_output, lcd_latch_output, serial_data_out, serial_clock_out, serial_clock_pin} = 5'h1F;
        cyc(4);
        chk(16'(out_pin_q), 16'h00FB);
        chk(16'(io_oe_q), 16'h0C6F);
        chk(16'(io_out_q & io_oe_q), 16'h0465);
        chk(16'({io_pu_q, 2'h0, serial_clock_in, serial_data_in}), 16'h3902);
        // Pin reset mid-run drops the selections
        pin_req = 1'b1;
        cyc(7);
        chk(16'(init_reset_q), 16'h0001);
        chk(16'({out_pin_q, io_oe_q[3:0]}), 16'hFFF0);
        pin_req = 1'b0;
        wait_run;
        // Key combination: partial set, short glitch, then a real hold
        keys_down = 4'h7;
        cyc(1500);
        chk(16'(init_reset_q), 16'h0000);
        keys_down = 4'hF;
        cyc(500);
        keys_down = 4'h0;
        cyc(10);
        chk(16'(init_reset_q), 16'h0000);
        keys_down = 4'hF;
        cyc(1300);
        chk(16'(init_reset_q), 16'h0001);
        keys_down = 4'h0;
        wait_run;
        end_sim;
    end
endmodule
